// ==== icx_exec.sv ====
// Summary of operation
// RULE_01: Decrement wraps zero to all ones, flags kept
// RULE_02: Decode decrement accumulator, register, direct; one cycle
// RULE_03: Port operands read from output latch
// RULE_04: Divide gives quotient, remainder; clears flags; four cycles
// RULE_05: Zero divisor sets overflow, clears carry
// RULE_06: Decrement and branch when nonzero; two cycles
// RULE_07: Decrement-branch operand register or direct only
// RULE_08: Increment wraps all ones to zero, flags kept
// RULE_09: Decode increment accumulator, register, indirect; one cycle
// RULE_10: Pointer increments sixteen bits; two cycles
// RULE_11: Bit-set branch, three bytes, bit unchanged
// RULE_12: Branch-and-clear clears set bit and branches
// RULE_13: Branch-and-clear tests output latch, not pin
// RULE_14: Bit branch target next address plus third byte
// RULE_15: Carry branch two bytes, two cycles, relative
// RULE_16: Displacement sign-extended, sixteen-bit wrapping add
`timescale 1ns/1ps
`default_nettype none
`include "icx_map.svh"

module icx_exec (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Instruction from fetch
  input wire logic instr_valid,
  input wire logic [7:0] opcode,
  input wire logic [7:0] byte2,
  input wire logic [7:0] byte3,
  input wire logic [15:0] pc_in,
  output logic instr_hit,
  output logic instr_ready,
  output logic done_q,
  // Core register values
  input wire logic [7:0] acc_in,
  input wire logic [7:0] b_in,
  input wire logic [15:0] data_pointer_in,
  input wire logic carry_in,
  input wire logic [1:0] bank_sel,
  input wire logic [7:0] r0_in,
  input wire logic [7:0] r1_in,
  // Core register updates
  output logic acc_wr_q,
  output logic [7:0] acc_wdata_q,
  output logic b_wr_q,
  output logic [7:0] b_wdata_q,
  output logic data_pointer_wr_q,
  output logic [15:0] data_pointer_wdata_q,
  output logic flag_wr_q,
  output logic carry_wdata_q,
  output logic ov_wdata_q,
  output logic pc_wr_q,
  output logic [15:0] pc_wdata_q,
  // Byte space: RAM, special registers, port latches
  output logic mem_rd_q,
  output logic mem_wr_q,
  output logic [7:0] mem_addr_q,
  output logic mem_indirect_q,
  output logic mem_latch_q,
  output logic [7:0] mem_wdata_q,
  input wire logic [7:0] mem_rdata,
  // Bit space
  output logic bit_rd_q,
  output logic bit_latch_q,
  output logic bit_clr_q,
  output logic [7:0] bit_addr_q,
  input wire logic bit_rdata
);

  icx_pkg::icx_state_t state_q;
  icx_pkg::icx_kind_t kind_q;
  icx_pkg::icx_opd_t opd_q;
  icx_pkg::icx_kind_t kind_d;
  icx_pkg::icx_opd_t opd_d;
  logic [3:0] cnt_q;
  logic [15:0] pc_next_q;
  logic [7:0] rel_q;
  logic [7:0] opnd_q;
  logic [15:0] data_pointer_q;
  logic carry_q;
  logic bit_q;
  logic bzero_q;
  logic rd_pend_q;
  logic take;
  logic fin;
  logic [7:0] val;
  logic [7:0] res;
  logic taken;
  logic [15:0] target;
  logic [7:0] div_quo;
  logic [7:0] div_rem;

  function automatic icx_pkg::icx_kind_t dec_kind(input logic [7:0] op);
    if (op == `ICX_OP_INC_A || op == `ICX_OP_INC_DIR || op[7:1] == `ICX_OP_INC_IND_HI ||
        op[7:3] == `ICX_OP_INC_RN_HI) begin
      dec_kind = icx_pkg::K_INC; // RULE_09
    end else if (op == `ICX_OP_DEC_A || op == `ICX_OP_DEC_DIR ||
                 op[7:1] == `ICX_OP_DEC_IND_HI || op[7:3] == `ICX_OP_DEC_RN_HI) begin
      dec_kind = icx_pkg::K_DEC; // RULE_02
    end else if (op == `ICX_OP_DECREMENT_BRANCH_NONZERO_OP_DIR || op[7:3] == `ICX_OP_DECREMENT_BRANCH_NONZERO_OP_RN_HI) begin
      dec_kind = icx_pkg::K_DECREMENT_BRANCH_NONZERO_OP; // RULE_07
    end else if (op == `ICX_OP_INC_DATA_POINTER) begin
      dec_kind = icx_pkg::K_DATA_POINTER;
    end else if (op == `ICX_OP_DIV) begin
      dec_kind = icx_pkg::K_DIV;
    end else if (op == `ICX_OP_JB) begin
      dec_kind = icx_pkg::K_JB;
    end else if (op == `ICX_OP_JBC) begin
      dec_kind = icx_pkg::K_JBC;
    end else if (op == `ICX_OP_JC) begin
      dec_kind = icx_pkg::K_JC;
    end else begin
      dec_kind = icx_pkg::K_NONE;
    end
  endfunction

  // Operand form follows the low opcode bits within each group
  function automatic icx_pkg::icx_opd_t dec_opd(input logic [7:0] op,
                                                input icx_pkg::icx_kind_t k);
    if (k == icx_pkg::K_INC || k == icx_pkg::K_DEC || k == icx_pkg::K_DECREMENT_BRANCH_NONZERO_OP) begin
      if (op[3]) begin
        dec_opd = icx_pkg::O_REG;
      end else if (op[2:0] == 3'h4) begin
        dec_opd = icx_pkg::O_ACC;
      end else if (op[2:0] == 3'h5) begin
        dec_opd = icx_pkg::O_DIR;
      end else begin
        dec_opd = icx_pkg::O_IND;
      end
    end else begin
      dec_opd = icx_pkg::O_NONE;
    end
  endfunction

  function automatic logic [15:0] dec_len(input icx_pkg::icx_kind_t k,
                                          input icx_pkg::icx_opd_t o);
    case (k)
      icx_pkg::K_JB, icx_pkg::K_JBC: dec_len = `ICX_LEN_THREE; // RULE_11
      icx_pkg::K_JC: dec_len = `ICX_LEN_TWO; // RULE_15
      icx_pkg::K_DECREMENT_BRANCH_NONZERO_OP: dec_len = (o == icx_pkg::O_DIR) ? `ICX_LEN_THREE : `ICX_LEN_TWO;
      icx_pkg::K_INC, icx_pkg::K_DEC: dec_len = (o == icx_pkg::O_DIR) ? `ICX_LEN_TWO
                                                                   : `ICX_LEN_ONE;
      default: dec_len = `ICX_LEN_ONE;
    endcase
  endfunction

  // Clocks spent from the taking edge to the completion edge
  function automatic logic [3:0] dec_clks(input icx_pkg::icx_kind_t k);
    case (k)
      icx_pkg::K_INC, icx_pkg::K_DEC: dec_clks = `ICX_MC_ONE * `ICX_CLKS_PER_MC;
      icx_pkg::K_DIV: dec_clks = `ICX_MC_DIV * `ICX_CLKS_PER_MC; // RULE_04
      default: dec_clks = `ICX_MC_TWO * `ICX_CLKS_PER_MC; // RULE_06 RULE_10 RULE_15
    endcase
  endfunction

  function automatic logic [15:0] sext(input logic [7:0] d);
    sext = {{8{d[7]}}, d}; // RULE_16
  endfunction

  assign kind_d = dec_kind(opcode);
  assign opd_d = dec_opd(opcode, kind_d);
  assign instr_hit = (kind_d != icx_pkg::K_NONE);
  assign instr_ready = (state_q == icx_pkg::ST_IDLE);
  assign take = instr_valid && instr_ready && instr_hit;
  assign fin = (state_q == icx_pkg::ST_BUSY) && (cnt_q == 4'h1);

  // Read data stands one cycle only; later completions use the captured copy
  assign val = rd_pend_q ? mem_rdata : opnd_q;
  assign res = (kind_q == icx_pkg::K_INC) ? 8'(val + `ICX_BYTE_ONE) // RULE_08
                                         : 8'(val - `ICX_BYTE_ONE); // RULE_01 RULE_06

  always_comb begin
    case (kind_q)
      icx_pkg::K_DECREMENT_BRANCH_NONZERO_OP: taken = (res != `ICX_RST_BYTE); // RULE_06
      icx_pkg::K_JB, icx_pkg::K_JBC: taken = bit_q; // RULE_11 RULE_12
      icx_pkg::K_JC: taken = carry_q; // RULE_15
      default: taken = 1'b0;
    endcase
  end

  assign target = taken ? 16'(pc_next_q + sext(rel_q)) : pc_next_q; // RULE_14 RULE_16

  icx_div u_div (
    .clk(clk),
    .rst_n(rst_n),
    .start(take && kind_d == icx_pkg::K_DIV),
    .dividend(acc_in),
    .divisor(b_in),
    .quotient(div_quo),
    .remainder(div_rem)
  );

  // Sequencing
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= icx_pkg::ST_IDLE;
      cnt_q <= `ICX_RST_CNT;
    end else begin
      case (state_q)
        icx_pkg::ST_IDLE: begin
          if (take) begin
            state_q <= icx_pkg::ST_BUSY;
            cnt_q <= dec_clks(kind_d);
          end
        end
        icx_pkg::ST_BUSY: begin
          cnt_q <= cnt_q - 4'h1;
          if (fin) begin
            state_q <= icx_pkg::ST_IDLE;
          end
        end
        default: state_q <= icx_pkg::ST_IDLE;
      endcase
    end
  end

  // Instruction capture
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      kind_q <= icx_pkg::K_NONE;
      opd_q <= icx_pkg::O_NONE;
      pc_next_q <= `ICX_RST_WORD;
      rel_q <= `ICX_RST_BYTE;
      data_pointer_q <= `ICX_RST_WORD;
      carry_q <= 1'b0;
      bzero_q <= 1'b0;
    end else if (take) begin
      kind_q <= kind_d;
      opd_q <= opd_d;
      pc_next_q <= 16'(pc_in + dec_len(kind_d, opd_d));
      rel_q <= (dec_len(kind_d, opd_d) == `ICX_LEN_THREE) ? byte3 : byte2; // RULE_14
      data_pointer_q <= data_pointer_in;
      carry_q <= carry_in;
      bzero_q <= (b_in == `ICX_RST_BYTE);
    end
  end

  // Operand capture: accumulator at take, memory and bit data on return
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      opnd_q <= `ICX_RST_BYTE;
      bit_q <= 1'b0;
      rd_pend_q <= 1'b0;
    end else begin
      rd_pend_q <= mem_rd_q || bit_rd_q;
      if (take) begin
        opnd_q <= acc_in;
      end else if (rd_pend_q) begin
        opnd_q <= mem_rdata;
        bit_q <= bit_rdata;
      end
    end
  end

  // Operand reads; address held on for the write-back
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_rd_q <= 1'b0;
      mem_addr_q <= `ICX_RST_BYTE;
      mem_indirect_q <= 1'b0;
      mem_latch_q <= 1'b0;
      bit_rd_q <= 1'b0;
      bit_latch_q <= 1'b0;
      bit_addr_q <= `ICX_RST_BYTE;
    end else if (take) begin
      mem_rd_q <= (opd_d != icx_pkg::O_NONE) && (opd_d != icx_pkg::O_ACC);
      mem_indirect_q <= (opd_d == icx_pkg::O_IND);
      mem_latch_q <= 1'b1; // RULE_03
      case (opd_d)
        icx_pkg::O_REG: mem_addr_q <= {`ICX_REG_PAGE, bank_sel, opcode[2:0]};
        icx_pkg::O_IND: mem_addr_q <= opcode[0] ? r1_in : r0_in;
        default: mem_addr_q <= byte2;
      endcase
      bit_rd_q <= (kind_d == icx_pkg::K_JB) || (kind_d == icx_pkg::K_JBC);
      bit_latch_q <= (kind_d == icx_pkg::K_JBC); // RULE_13
      bit_addr_q <= byte2;
    end else begin
      mem_rd_q <= 1'b0;
      bit_rd_q <= 1'b0;
    end
  end

  // Completion: write-back, flags, program counter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      done_q <= 1'b0;
      acc_wr_q <= 1'b0;
      acc_wdata_q <= `ICX_RST_BYTE;
      b_wr_q <= 1'b0;
      b_wdata_q <= `ICX_RST_BYTE;
      data_pointer_wr_q <= 1'b0;
      data_pointer_wdata_q <= `ICX_RST_WORD;
      flag_wr_q <= 1'b0;
      carry_wdata_q <= 1'b0;
      ov_wdata_q <= 1'b0;
      pc_wr_q <= 1'b0;
      pc_wdata_q <= `ICX_RST_WORD;
      mem_wr_q <= 1'b0;
      mem_wdata_q <= `ICX_RST_BYTE;
      bit_clr_q <= 1'b0;
    end else begin
      done_q <= fin;
      pc_wr_q <= fin;
      acc_wr_q <= 1'b0;
      b_wr_q <= 1'b0;
      data_pointer_wr_q <= 1'b0;
      flag_wr_q <= 1'b0;
      mem_wr_q <= 1'b0;
      bit_clr_q <= 1'b0;
      if (fin) begin
        pc_wdata_q <= target;
        case (kind_q)
          icx_pkg::K_INC, icx_pkg::K_DEC, icx_pkg::K_DECREMENT_BRANCH_NONZERO_OP: begin
            if (opd_q == icx_pkg::O_ACC) begin
              acc_wr_q <= 1'b1;
              acc_wdata_q <= res;
            end else begin
              mem_wr_q <= 1'b1;
              mem_wdata_q <= res;
            end
          end
          icx_pkg::K_DATA_POINTER: begin
            data_pointer_wr_q <= 1'b1;
            data_pointer_wdata_q <= 16'(data_pointer_q + `ICX_WORD_ONE); // RULE_10
          end
          icx_pkg::K_DIV: begin
            // Zero divisor: the divider's output is left as is, not defined
            acc_wr_q <= 1'b1;
            acc_wdata_q <= div_quo; // RULE_04
            b_wr_q <= 1'b1;
            b_wdata_q <= div_rem;
            flag_wr_q <= 1'b1;
            carry_wdata_q <= 1'b0;
            ov_wdata_q <= bzero_q; // RULE_05
          end
          icx_pkg::K_JBC: bit_clr_q <= bit_q; // RULE_12
          default: bit_clr_q <= 1'b0;
        endcase
      end
    end
  end

  dec_acc_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
    take && opcode == `ICX_OP_DEC_A |-> ##3 acc_wr_q && !flag_wr_q &&
      acc_wdata_q == 8'($past(acc_in, 3) - 8'h01))
    else $error("Accumulator decrement result wrong");

  dec_timing_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
    take && opcode[7:3] == `ICX_OP_DEC_RN_HI |-> ##1 !done_q[*2] ##1 done_q && mem_wr_q)
    else $error("Register decrement not done in one cycle");

  latch_read_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
    mem_rd_q |-> mem_latch_q)
    else $error("Operand read not from output latch");

  div_time_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
    take && opcode == `ICX_OP_DIV && b_in != 8'h00 |-> ##1 !done_q[*8] ##1 done_q &&
      flag_wr_q && !carry_wdata_q && !ov_wdata_q &&
      acc_wdata_q == 8'($past(acc_in, 9) / $past(b_in, 9)) &&
      b_wdata_q == 8'($past(acc_in, 9) % $past(b_in, 9)))
    else $error("Divide result or timing wrong");

  div_zero_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_05
    take && opcode == `ICX_OP_DIV && b_in == 8'h00 |-> ##9 flag_wr_q && ov_wdata_q &&
      !carry_wdata_q)
    else $error("Zero divisor flags wrong");

  decrement_branch_nonzero_op_time_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_06
    take && opcode[7:3] == `ICX_OP_DECREMENT_BRANCH_NONZERO_OP_RN_HI |-> ##5 done_q && pc_wr_q && !flag_wr_q)
    else $error("Decrement-branch timing wrong");

  inc_acc_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_08
    take && opcode == `ICX_OP_INC_A |-> ##3 acc_wr_q && !flag_wr_q &&
      acc_wdata_q == 8'($past(acc_in, 3) + 8'h01))
    else $error("Accumulator increment result wrong");

  data_pointer_inc_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_10
    take && opcode == `ICX_OP_INC_DATA_POINTER |-> ##5 data_pointer_wr_q && done_q &&
      data_pointer_wdata_q == 16'($past(data_pointer_in, 5) + 16'h0001))
    else $error("Pointer increment wrong");

  jc_target_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_15
    take && opcode == `ICX_OP_JC && carry_in |-> ##5 pc_wr_q &&
      pc_wdata_q == 16'($past(pc_in, 5) + 16'h0002 + sext($past(byte2, 5))))
    else $error("Carry branch target wrong");

  jbc_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_12
    bit_clr_q |-> pc_wr_q && bit_latch_q && pc_wdata_q == 16'(pc_next_q + sext(rel_q)))
    else $error("Bit cleared without branch");

endmodule // icx_exec

`default_nettype wire

// ==== icx_map.svh ====
`ifndef ICX_MAP_SVH
`define ICX_MAP_SVH

// Opcodes, full byte or upper bits of the byte
`define ICX_OP_INC_A 8'h04
`define ICX_OP_INC_DIR 8'h05
`define ICX_OP_INC_IND_HI 7'h03
`define ICX_OP_INC_RN_HI 5'h01
`define ICX_OP_DEC_A 8'h14
`define ICX_OP_DEC_DIR 8'h15
`define ICX_OP_DEC_IND_HI 7'h0b
`define ICX_OP_DEC_RN_HI 5'h03
`define ICX_OP_INC_DATA_POINTER 8'ha3
`define ICX_OP_DIV 8'h84
`define ICX_OP_DECREMENT_BRANCH_NONZERO_OP_RN_HI 5'h1b
`define ICX_OP_DECREMENT_BRANCH_NONZERO_OP_DIR 8'hd5
`define ICX_OP_JB 8'h20
`define ICX_OP_JBC 8'h10
`define ICX_OP_JC 8'h40

// Timing: clocks per machine cycle and machine cycles per instruction
`define ICX_CLKS_PER_MC 4'h2
`define ICX_MC_ONE 4'h1
`define ICX_MC_TWO 4'h2
`define ICX_MC_DIV 4'h4
`define ICX_DIV_STEPS 4'h7

// Instruction lengths in bytes
`define ICX_LEN_ONE 16'h0001
`define ICX_LEN_TWO 16'h0002
`define ICX_LEN_THREE 16'h0003

// Working register page and constants
`define ICX_REG_PAGE 3'h0
`define ICX_BYTE_ONE 8'h01
`define ICX_WORD_ONE 16'h0001
`define ICX_RST_BYTE 8'h00
`define ICX_RST_WORD 16'h0000
`define ICX_RST_CNT 4'h0

`endif

// ==== icx_pkg.sv ====
package icx_pkg;

  typedef enum logic [3:0] {
    K_NONE = 4'h0,
    K_INC = 4'h1,
    K_DEC = 4'h2,
    K_DECREMENT_BRANCH_NONZERO_OP = 4'h3,
    K_DATA_POINTER = 4'h4,
    K_DIV = 4'h5,
    K_JB = 4'h6,
    K_JBC = 4'h7,
    K_JC = 4'h8
  } icx_kind_t;

  typedef enum logic [2:0] {
    O_NONE = 3'h0,
    O_ACC = 3'h1,
    O_REG = 3'h2,
    O_DIR = 3'h3,
    O_IND = 3'h4
  } icx_opd_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } icx_state_t;

endpackage

// ==== icx_div.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "icx_map.svh"

module icx_div (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Operands
  input wire logic start,
  input wire logic [7:0] dividend,
  input wire logic [7:0] divisor,
  // Results, valid seven clocks after start
  output logic [7:0] quotient,
  output logic [7:0] remainder
);

  logic [7:0] dvs_q;
  logic [3:0] cnt_q;

  // One restoring step: shift in next dividend bit, subtract if it fits
  function automatic logic [15:0] step(input logic [7:0] rem, input logic [7:0] quo,
                                       input logic [7:0] dvs);
    logic [8:0] trial;
    trial = {rem, quo[7]};
    if (trial >= {1'b0, dvs}) begin
      step = {8'(trial - {1'b0, dvs}), quo[6:0], 1'b1};
    end else begin
      step = {trial[7:0], quo[6:0], 1'b0};
    end
  endfunction

  // First step taken on the start edge so eight steps fit four machine cycles
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      remainder <= `ICX_RST_BYTE;
      quotient <= `ICX_RST_BYTE;
      dvs_q <= `ICX_RST_BYTE;
      cnt_q <= `ICX_RST_CNT;
    end else if (start) begin
      {remainder, quotient} <= step(`ICX_RST_BYTE, dividend, divisor);
      dvs_q <= divisor;
      cnt_q <= `ICX_DIV_STEPS;
    end else if (cnt_q != `ICX_RST_CNT) begin
      {remainder, quotient} <= step(remainder, quotient, dvs_q);
      cnt_q <= cnt_q - 4'h1;
    end
  end

endmodule // icx_div

`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "icx_map.svh"

module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic instr_valid = 1'b0, carry_in = 1'b0, bit_rdata = 1'b0;
  logic [7:0] opcode = 8'h00, byte2 = 8'h00, byte3 = 8'h00, acc_in = 8'h00, b_in = 8'h00;
  logic [7:0] r0_in = 8'h00, r1_in = 8'h00, mem_rdata = 8'h00;
  logic [15:0] pc_in = 16'h0000, data_pointer_in = 16'h0000;
  logic [1:0] bank_sel = 2'h0;
  logic instr_hit, instr_ready, done_q, acc_wr_q, b_wr_q, data_pointer_wr_q, flag_wr_q, carry_wdata_q;
  logic ov_wdata_q, pc_wr_q, mem_rd_q, mem_wr_q, mem_indirect_q, mem_latch_q;
  logic bit_rd_q, bit_latch_q, bit_clr_q;
  logic [7:0] acc_wdata_q, b_wdata_q, mem_addr_q, mem_wdata_q, bit_addr_q;
  logic [15:0] data_pointer_wdata_q, pc_wdata_q;
  int error_cnt = 0;
  int comparisons = 0;

  icx_exec dut (
    .clk(clk), .rst_n(rst_n), .instr_valid(instr_valid), .opcode(opcode), .byte2(byte2),
    .byte3(byte3), .pc_in(pc_in), .instr_hit(instr_hit), .instr_ready(instr_ready),
    .done_q(done_q), .acc_in(acc_in), .b_in(b_in), .data_pointer_in(data_pointer_in), .carry_in(carry_in),
    .bank_sel(bank_sel), .r0_in(r0_in), .r1_in(r1_in), .acc_wr_q(acc_wr_q),
    .acc_wdata_q(acc_wdata_q), .b_wr_q(b_wr_q), .b_wdata_q(b_wdata_q), .data_pointer_wr_q(data_pointer_wr_q),
    .data_pointer_wdata_q(data_pointer_wdata_q), .flag_wr_q(flag_wr_q), .carry_wdata_q(carry_wdata_q),
    .ov_wdata_q(ov_wdata_q), .pc_wr_q(pc_wr_q), .pc_wdata_q(pc_wdata_q), .mem_rd_q(mem_rd_q),
    .mem_wr_q(mem_wr_q), .mem_addr_q(mem_addr_q), .mem_indirect_q(mem_indirect_q),
    .mem_latch_q(mem_latch_q), .mem_wdata_q(mem_wdata_q), .mem_rdata(mem_rdata),
    .bit_rd_q(bit_rd_q), .bit_latch_q(bit_latch_q), .bit_clr_q(bit_clr_q),
    .bit_addr_q(bit_addr_q), .bit_rdata(bit_rdata)
  );

  always #5 clk = ~clk;

  task automatic chk(input logic ok, input string msg);
    begin
      comparisons++;
      if (ok !== 1'b1) begin
        error_cnt++;
        $display("ERROR at %0t: %s", $time, msg);
      end
    end
  endtask

  task automatic test_done;
    begin
      $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
        $display("All tests passed");
      end else begin
        $display("Some tests failed");
      end
      $finish;
    end
  endtask

  // Seen bits: mem rd, mem wr, bit rd, bit clr, acc, b, flags, pointer, pc, latch read
  task automatic run(input logic [7:0] op, b2, b3, input logic [15:0] pc, input int mc,
                     input logic [9:0] exp_seen, input logic [15:0] exp_pc);
    logic [9:0] seen;
    int n;
    begin
      opcode = op;
      byte2 = b2;
      byte3 = b3;
      pc_in = pc;
      instr_valid = 1'b1;
      seen = 10'h000;
      n = 0;
      #1;
      chk(instr_hit === 1'b1 && instr_ready === 1'b1, "offer not accepted");
      do begin
        @(negedge clk);
        instr_valid = 1'b0;
        n++;
        seen = seen | {mem_rd_q === 1'b1, mem_wr_q === 1'b1, bit_rd_q === 1'b1,
                       bit_clr_q === 1'b1, acc_wr_q === 1'b1, b_wr_q === 1'b1,
                       flag_wr_q === 1'b1, data_pointer_wr_q === 1'b1, pc_wr_q === 1'b1,
                       (mem_rd_q & mem_latch_q) === 1'b1 ||
                       (bit_rd_q & bit_latch_q & (op == `ICX_OP_JBC)) === 1'b1};
      end while (done_q !== 1'b1 && n < 12);
      if (done_q !== 1'b1) begin
        error_cnt++;
        $display("ERROR at %0t: no completion", $time);
        test_done();
      end else begin
        chk(n == 2 * mc + 1, "wrong cycle count");
        chk(seen === exp_seen, "wrong set of updates");
        chk(pc_wdata_q === exp_pc && instr_ready === 1'b1, "wrong next address");
      end
    end
  endtask

  function automatic logic [15:0] tgt(input logic [15:0] pc, input logic [15:0] len,
                                      input logic [7:0] rel, input logic take);
    tgt = pc + len + (take ? {{8{rel[7]}}, rel} : 16'h0000);
  endfunction

  task automatic t_acc;
    begin
      acc_in = 8'h00;
      run(`ICX_OP_DEC_A, 8'h00, 8'h00, 16'h0100, 1, 10'h022, 16'h0101);
      chk(acc_wdata_q === 8'hff, "acc decrement");
      acc_in = 8'hff;
      run(`ICX_OP_INC_A, 8'h00, 8'h00, 16'hffff, 1, 10'h022, 16'h0000);
      chk(acc_wdata_q === 8'h00, "acc increment");
      $display("Test acc finished");
    end
  endtask

  task automatic t_mem;
    begin
      for (int r = 0; r < 8; r++) begin
        bank_sel = r[1:0];
        mem_rdata = r[7:0];
        run({`ICX_OP_DEC_RN_HI, r[2:0]}, 8'h00, 8'h00, 16'h0200, 1, 10'h303, 16'h0201);
        chk(mem_addr_q === {3'h0, r[1:0], r[2:0]} && mem_wdata_q === r[7:0] - 8'h01,
            "reg decrement");
        mem_rdata = 8'hff - r[7:0];
        run({`ICX_OP_INC_RN_HI, r[2:0]}, 8'h00, 8'h00, 16'h0200, 1, 10'h303, 16'h0201);
        chk(mem_addr_q === {3'h0, r[1:0], r[2:0]} && mem_wdata_q === 8'h00 - r[7:0],
            "reg increment");
      end
      mem_rdata = 8'h5a;
      run(`ICX_OP_DEC_DIR, 8'h90, 8'h00, 16'h0300, 1, 10'h303, 16'h0302);
      chk(mem_addr_q === 8'h90 && mem_wdata_q === 8'h59, "direct decrement");
      mem_rdata = 8'h7f;
      run(`ICX_OP_INC_DIR, 8'ha0, 8'h00, 16'h0300, 1, 10'h303, 16'h0302);
      chk(mem_addr_q === 8'ha0 && mem_wdata_q === 8'h80, "direct increment");
      r0_in = 8'h11;
      r1_in = 8'h7e;
      mem_rdata = 8'hff;
      run({`ICX_OP_INC_IND_HI, 1'b1}, 8'h00, 8'h00, 16'h0400, 1, 10'h303, 16'h0401);
      chk(mem_addr_q === 8'h7e && mem_indirect_q === 1'b1 && mem_wdata_q === 8'h00,
          "indirect increment");
      r0_in = 8'h7f;
      mem_rdata = 8'h40;
      run({`ICX_OP_DEC_IND_HI, 1'b0}, 8'h00, 8'h00, 16'h0400, 1, 10'h303, 16'h0401);
      chk(mem_addr_q === 8'h7f && mem_wdata_q === 8'h3f, "indirect decrement");
      $display("Test memory forms finished");
    end
  endtask

  task automatic t_div;
    logic [7:0] da [4] = '{8'hfb, 8'hff, 8'h07, 8'h00};
    logic [7:0] db [4] = '{8'h12, 8'h01, 8'h09, 8'h05};
    begin
      for (int i = 0; i < 4; i++) begin
        acc_in = da[i];
        b_in = db[i];
        run(`ICX_OP_DIV, 8'h00, 8'h00, 16'h0500, 4, 10'h03a, 16'h0501);
        chk(acc_wdata_q === da[i] / db[i] && b_wdata_q === da[i] % db[i] &&
            carry_wdata_q === 1'b0 && ov_wdata_q === 1'b0, "divide result");
      end
      b_in = 8'h00;
      run(`ICX_OP_DIV, 8'h00, 8'h00, 16'h0500, 4, 10'h03a, 16'h0501);
      chk(carry_wdata_q === 1'b0 && ov_wdata_q === 1'b1, "divide by zero flags");
      $display("Test divide finished");
    end
  endtask

  task automatic t_decrement_branch_nonzero_op;
    begin
      bank_sel = 2'h1;
      mem_rdata = 8'h01;
      run({`ICX_OP_DECREMENT_BRANCH_NONZERO_OP_RN_HI, 3'h3}, 8'h10, 8'h00, 16'h0600, 2, 10'h303,
          tgt(16'h0600, 16'h0002, 8'h10, 1'b0));
      chk(mem_addr_q === 8'h0b && mem_wdata_q === 8'h00, "loop count to zero");
      mem_rdata = 8'h00;
      run({`ICX_OP_DECREMENT_BRANCH_NONZERO_OP_RN_HI, 3'h3}, 8'h80, 8'h00, 16'h0010, 2, 10'h303,
          tgt(16'h0010, 16'h0002, 8'h80, 1'b1));
      chk(mem_wdata_q === 8'hff, "loop count wrap");
      mem_rdata = 8'h70;
      run(`ICX_OP_DECREMENT_BRANCH_NONZERO_OP_DIR, 8'h40, 8'h05, 16'h1000, 2, 10'h303,
          tgt(16'h1000, 16'h0003, 8'h05, 1'b1));
      chk(mem_addr_q === 8'h40 && mem_wdata_q === 8'h6f, "direct loop count");
      $display("Test loop branch finished");
    end
  endtask

  task automatic t_data_pointer;
    logic [15:0] dp [3] = '{16'h12fe, 16'h12ff, 16'hffff};
    begin
      for (int i = 0; i < 3; i++) begin
        data_pointer_in = dp[i];
        run(`ICX_OP_INC_DATA_POINTER, 8'h00, 8'h00, 16'h0700, 2, 10'h006, 16'h0701);
        chk(data_pointer_wdata_q === dp[i] + 16'h0001, "pointer increment");
      end
      $display("Test pointer finished");
    end
  endtask

  task automatic t_bits;
    begin
      for (int v = 0; v < 2; v++) begin
        bit_rdata = v[0];
        run(`ICX_OP_JB, 8'h92, 8'hfe, 16'h0300, 2, 10'h082,
            tgt(16'h0300, 16'h0003, 8'hfe, v[0]));
        chk(bit_addr_q === 8'h92, "bit address");
        run(`ICX_OP_JBC, 8'h97, 8'h7f, 16'hff80, 2, v[0] ? 10'h0c3 : 10'h083,
            tgt(16'hff80, 16'h0003, 8'h7f, v[0]));
        chk(bit_addr_q === 8'h97, "clear bit address");
      end
      $display("Test bit branches finished");
    end
  endtask

  task automatic t_carry;
    begin
      for (int v = 0; v < 4; v++) begin
        carry_in = v[0];
        run(`ICX_OP_JC, v[1] ? 8'h80 : 8'h7f, 8'h00, v[1] ? 16'hff00 : 16'h0400, 2, 10'h002,
            tgt(v[1] ? 16'hff00 : 16'h0400, 16'h0002, v[1] ? 8'h80 : 8'h7f, v[0]));
      end
      $display("Test carry branch finished");
    end
  endtask

  // Neighbouring codes outside the group must never start anything
  task automatic t_refuse;
    logic [7:0] ops [4] = '{8'hd6, 8'hd7, 8'h30, 8'h50};
    begin
      for (int i = 0; i < 4; i++) begin
        opcode = ops[i];
        instr_valid = 1'b1;
        #1;
        chk(instr_hit === 1'b0, "foreign opcode claimed");
        repeat (4) begin
          @(negedge clk);
          chk(done_q === 1'b0 && pc_wr_q === 1'b0 && mem_wr_q === 1'b0, "foreign run");
        end
      end
      instr_valid = 1'b0;
      $display("Test foreign opcodes finished");
    end
  endtask

  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk(instr_ready === 1'b1 && done_q === 1'b0 && pc_wr_q === 1'b0, "reset state");
    t_acc();
    t_mem();
    t_div();
    t_decrement_branch_nonzero_op();
    t_data_pointer();
    t_bits();
    t_carry();
    t_refuse();
    test_done();
  end
endmodule // tb_top

`default_nettype wire
